// ==== verilog/nsx_pkg.sv ====
package nsx_pkg;

    // instruction word layout (12 bits)
    localparam int          INSN_W          = 12;
    localparam int          DATA_W          = 8;
    localparam int          ADDR_W          = 5;
    localparam int          DEST_BIT        = 5;
    localparam int          ADDR_LSB        = 0;
    localparam int          LIT_LSB         = 0;

    // opcode patterns
    localparam logic [5:0]  SWAP_OPC        = 6'h0E;   // 0011 10
    localparam logic [5:0]  XORF_OPC        = 6'h06;   // 0001 10
    localparam logic [3:0]  XORL_OPC        = 4'hF;    // 1111
    localparam logic [11:0] DIRL_BASE       = 12'h000; // 0000 0000 0fff
    localparam logic [2:0]  DIRL_PORT       = 3'h6;

    // reset values
    localparam logic [7:0]  W_RESET         = 8'h00;
    localparam logic [7:0]  DIR_RESET       = 8'hFF;
    localparam logic [7:0]  ZERO_BYTE       = 8'h00;

    typedef enum logic [2:0] {
        NSX_OP_NONE = 3'b000,
        NSX_OP_SWAP = 3'b001,
        NSX_OP_DIRL = 3'b010,
        NSX_OP_XORL = 3'b011,
        NSX_OP_XORF = 3'b100
    } nsx_op_e;

endpackage

// ==== verilog/nsx_dec_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface nsx_dec_if;
    logic [11:0]        insn;
    nsx_pkg::nsx_op_e   op;
    logic               dest_f;
    logic [4:0]         addr;
    logic [7:0]         lit;

    modport dec (input insn, output op, output dest_f, output addr, output lit);
    modport exe (output insn, input op, input dest_f, input addr, input lit);
endinterface
`default_nettype wire

// ==== verilog/nsx_decoder.sv ====
`timescale 1ns/1ns
`default_nettype none
module nsx_decoder
(
    // decode link
    nsx_dec_if.dec  dif
);
    always_comb
    begin
        dif.dest_f = dif.insn[nsx_pkg::DEST_BIT];
        dif.addr   = dif.insn[nsx_pkg::ADDR_LSB +: nsx_pkg::ADDR_W];
        dif.lit    = dif.insn[nsx_pkg::LIT_LSB +: nsx_pkg::DATA_W];
        if (dif.insn[11:6] == nsx_pkg::SWAP_OPC)
            dif.op = nsx_pkg::NSX_OP_SWAP; // RQ3
        else if (dif.insn[11:6] == nsx_pkg::XORF_OPC)
            dif.op = nsx_pkg::NSX_OP_XORF; // RQ6
        else if (dif.insn[11:8] == nsx_pkg::XORL_OPC)
            dif.op = nsx_pkg::NSX_OP_XORL; // RQ5
        else if (dif.insn == (nsx_pkg::DIRL_BASE | {9'h000, nsx_pkg::DIRL_PORT}))
            dif.op = nsx_pkg::NSX_OP_DIRL; // RQ4
        else
            dif.op = nsx_pkg::NSX_OP_NONE;
    end
endmodule // nsx_decoder
`default_nettype wire

// ==== verilog/nsx_exec.sv ====
// What this block does
// RQ1: swap puts file bits 3:0 in result 7:4 and bits 7:4 in 3:0.
// RQ2: swap result goes to working register if d is 0, file if d is 1.
// RQ3: swap leaves flags alone, one word, one cycle, d and five-bit address.
// RQ4: direction load copies working register to port 6 direction, flags untouched.
// RQ5: literal xor replaces working register with it xor 8-bit literal, opcode 1111.
// RQ6: register xor combines working and file register in one cycle.
// RQ7: register xor result to working register if d is 0, file if 1.
// RQ8: both xors set zero flag on zero result, carry flags untouched.
`timescale 1ns/1ns
`default_nettype none
module nsx_exec
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // instruction issue
    input  wire logic        insn_valid,
    input  wire logic [11:0] insn,
    // file register read data for the addressed file
    input  wire logic [7:0]  file_rdata,
    // file register write-back
    output logic             file_we,
    output logic [4:0]       file_waddr,
    output logic [7:0]       file_wdata,
    // architectural state
    output logic [7:0]       w_reg,
    output logic [7:0]       dir_reg,
    output logic             zero_flag_reg,
    output logic             zero_we
);
    // decode link between the word decoder and this datapath
    nsx_dec_if          dif ();

    nsx_decoder nsx_decoder_inst
    (
        .dif            (dif)
    );

    assign dif.insn = insn;

    // nibble exchange of one byte
    function automatic logic [7:0] nib_swap
    (
        input logic [7:0]       v
    );
        return {v[3:0], v[7:4]}; // RQ1
    endfunction

    // xor ops are the only ones that touch the zero flag
    function automatic logic is_xor_op
    (
        input nsx_pkg::nsx_op_e op
    );
        return (op == nsx_pkg::NSX_OP_XORF) || (op == nsx_pkg::NSX_OP_XORL); // RQ3 RQ8
    endfunction

    // ops whose d bit picks working register or file
    function automatic logic has_dest
    (
        input nsx_pkg::nsx_op_e op
    );
        return (op == nsx_pkg::NSX_OP_SWAP) || (op == nsx_pkg::NSX_OP_XORF);
    endfunction

    // all-zero test for the zero flag
    function automatic logic is_zero
    (
        input logic [7:0]       v
    );
        return v == nsx_pkg::ZERO_BYTE;
    endfunction

    // issue qualification and shared result
    logic               go;
    logic               to_file;
    logic [7:0]         result;

    // next values, one per register
    logic [7:0]         w_next;
    logic [7:0]         dir_next;
    logic               zero_flag_next;
    logic               zero_we_next;
    logic               file_we_next;
    logic [4:0]         file_waddr_next;
    logic [7:0]         file_wdata_next;

    // an issued word counts only when it decodes to one of these ops
    always_comb
    begin
        go = 1'b0;
        if (insn_valid)
        begin
            case (dif.op)
                nsx_pkg::NSX_OP_SWAP,
                nsx_pkg::NSX_OP_XORF,
                nsx_pkg::NSX_OP_XORL,
                nsx_pkg::NSX_OP_DIRL:
                    go = 1'b1;
                nsx_pkg::NSX_OP_NONE:
                    go = 1'b0;
                default:
                    go = 1'b0;
            endcase
        end
    end

    // destination select, d bit only for swap and register xor
    always_comb
    begin
        to_file = 1'b0;
        if (has_dest(dif.op))
            to_file = dif.dest_f; // RQ2 RQ7
    end

    // shared result path
    always_comb
    begin
        result = nsx_pkg::ZERO_BYTE;
        case (dif.op)
            nsx_pkg::NSX_OP_SWAP:
                result = nib_swap(file_rdata); // RQ1
            nsx_pkg::NSX_OP_XORF:
                result = w_reg ^ file_rdata; // RQ6
            nsx_pkg::NSX_OP_XORL:
                result = w_reg ^ dif.lit; // RQ5
            nsx_pkg::NSX_OP_DIRL:
                result = w_reg; // RQ4
            nsx_pkg::NSX_OP_NONE:
                result = nsx_pkg::ZERO_BYTE;
            default:
                result = nsx_pkg::ZERO_BYTE;
        endcase
    end

    // working register: swap or register xor with d = 0, literal xor
    always_comb
    begin
        if (go && !to_file && dif.op != nsx_pkg::NSX_OP_DIRL)
            w_next = result; // RQ2
        else
            w_next = w_reg;
    end

    // direction register: only the direction load with operand 6
    always_comb
    begin
        if (go && dif.op == nsx_pkg::NSX_OP_DIRL)
            dir_next = result; // RQ4
        else
            dir_next = dir_reg;
    end

    // zero flag: xor ops only, swap and direction load leave it
    always_comb
    begin
        zero_we_next = go && is_xor_op(dif.op); // RQ8
        if (go && is_xor_op(dif.op))
            zero_flag_next = is_zero(result); // RQ8
        else
            zero_flag_next = zero_flag_reg;
    end

    // file write-back request for swap and register xor with d = 1
    always_comb
    begin
        file_we_next    = go && to_file; // RQ7
        file_waddr_next = dif.addr;
        file_wdata_next = result;
    end

    // working register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            w_reg <= nsx_pkg::W_RESET;
        else
            w_reg <= w_next;
    end

    // direction register
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            dir_reg <= nsx_pkg::DIR_RESET;
        else
            dir_reg <= dir_next;
    end

    // zero flag
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            zero_flag_reg <= 1'b0;
        else
            zero_flag_reg <= zero_flag_next;
    end

    // zero flag update pulse, one cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            zero_we <= 1'b0;
        else
            zero_we <= zero_we_next;
    end

    // file write pulse, one cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            file_we <= 1'b0;
        else
            file_we <= file_we_next;
    end

    // file write address
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            file_waddr <= 5'h00;
        else
            file_waddr <= file_waddr_next;
    end

    // file write data
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            file_wdata <= 8'h00;
        else
            file_wdata <= file_wdata_next;
    end
endmodule // nsx_exec
`default_nettype wire

// ==== test/nsx_exec_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module nsx_exec_monitor
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // instruction issue
    input  wire logic        insn_valid,
    input  wire logic [11:0] insn,
    input  wire logic [7:0]  file_rdata,
    // file write-back
    input  wire logic        file_we,
    input  wire logic [4:0]  file_waddr,
    input  wire logic [7:0]  file_wdata,
    // architectural state
    input  wire logic [7:0]  w_reg,
    input  wire logic [7:0]  dir_reg,
    input  wire logic        zero_flag_reg,
    input  wire logic        zero_we
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic       sw = insn_valid && insn[11:6] == 6'h0E;
    wire logic       xl = insn_valid && insn[11:8] == 4'hF;
    wire logic       xf = insn_valid && insn[11:6] == 6'h06;
    wire logic [7:0] sr = {file_rdata[3:0], file_rdata[7:4]};
    wire logic [7:0] xr = xl ? w_reg ^ insn[7:0] : w_reg ^ file_rdata;
    property p_sw_f; sw && insn[5] |=> file_we && file_wdata == $past(sr); endproperty
    a_sw_f: assert property (p_sw_f) else $error("swap file bad");
    property p_sw_w; sw && !insn[5] |=> !file_we && w_reg == $past(sr); endproperty
    a_sw_w: assert property (p_sw_w) else $error("swap w bad");
    property p_sw_z; sw |=> !zero_we && $stable(zero_flag_reg); endproperty
    a_sw_z: assert property (p_sw_z) else $error("swap flag bad");
    property p_dl; insn_valid && insn == 12'h006 |=> dir_reg == $past(w_reg) && !zero_we; endproperty
    a_dl: assert property (p_dl) else $error("dir bad");
    property p_xl; xl |=> w_reg == $past(xr) && !file_we; endproperty
    a_xl: assert property (p_xl) else $error("xor lit bad");
    property p_xf_f;
        xf && insn[5] |=> file_we && file_waddr == $past(insn[4:0]) && file_wdata == $past(xr);
    endproperty
    a_xf_f: assert property (p_xf_f) else $error("xor file bad");
    property p_xf_w; xf && !insn[5] |=> !file_we && w_reg == $past(xr); endproperty
    a_xf_w: assert property (p_xf_w) else $error("xor w bad");
    property p_z; xl || xf |=> zero_we && zero_flag_reg == ($past(xr) == 8'h00); endproperty
    a_z: assert property (p_z) else $error("zero bad");
    c_sw: cover property (sw && insn[5]);
    c_xl: cover property (xl);
    c_xf: cover property (xf && !insn[5]);
    property p_sw_keep; sw && insn[5] |=> $stable(w_reg); endproperty
    a_sw_keep: assert property (p_sw_keep) else $error("swap w kept bad");
    property p_dl_keep; insn_valid && insn == 12'h005 |=> $stable(dir_reg); endproperty
    a_dl_keep: assert property (p_dl_keep) else $error("dir operand bad");
    c_dl: cover property (insn_valid && insn == 12'h006);
endmodule // nsx_exec_monitor
bind nsx_exec nsx_exec_monitor nsx_exec_monitor_inst (.core_clk, .rst, .insn_valid, .file_we, .zero_flag_reg,
    .zero_we, .insn, .file_rdata, .file_wdata, .w_reg, .dir_reg, .file_waddr);
`default_nettype wire

// ==== test/nibble_swap_direction_load_op_xor_exec_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module nibble_swap_direction_load_op_xor_exec_test;
    logic        core_clk, rst, insn_valid, file_we, zero_flag_reg, zero_we;
    logic [11:0] insn;
    logic [7:0]  file_rdata, file_wdata, w_reg, dir_reg;
    logic [4:0]  file_waddr;
    int          mismatches, tests_run;
    nsx_exec nsx_exec_inst (.core_clk, .rst, .insn_valid, .insn, .file_rdata, .file_we, .file_waddr,
        .file_wdata, .w_reg, .dir_reg, .zero_flag_reg, .zero_we);
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
            mismatches++;
        end
    endtask
    // one issue cycle, then results are settled
    task automatic exec(input logic [11:0] i, input logic [7:0] f);
        @(negedge core_clk);
        insn_valid = 1'b1;
        insn = i;
        file_rdata = f;
        @(negedge core_clk);
        insn_valid = 1'b0;
    endtask
    task automatic t_swap;
        exec(12'h385, 8'hA5);
        chk(w_reg, 8'h5A);
        chk(file_we, 1'b0);
        exec(12'h3B1, 8'h3C);
        chk(file_we, 1'b1);
        chk(file_waddr, 8'h11);
        chk(file_wdata, 8'hC3);
        chk(w_reg, 8'h5A);
        chk(zero_we, 1'b0);
    endtask
    task automatic t_dirl;
        exec(12'h006, 8'h00);
        chk(dir_reg, 8'h5A);
        chk(zero_we, 1'b0);
    endtask
    task automatic t_xorl;
        exec(12'hFAF, 8'h00);
        chk(w_reg, 8'hF5);
        chk(zero_we, 1'b1);
        chk(zero_flag_reg, 1'b0);
        exec(12'hFF5, 8'h00);
        chk(zero_flag_reg, 1'b1);
        exec(12'hFB5, 8'h00);
        chk(w_reg, 8'hB5);
        chk(file_we, 1'b0);
    endtask
    task automatic t_xorf;
        exec(12'h1A5, 8'hAF);
        chk(file_we, 1'b1);
        chk(file_wdata, 8'h1A);
        chk(file_waddr, 8'h05);
        chk(w_reg, 8'hB5);
        chk(zero_flag_reg, 1'b0);
        exec(12'h185, 8'hAF);
        chk(w_reg, 8'h1A);
        chk(file_we, 1'b0);
    endtask
    task automatic t_flags;
        exec(12'h1A5, 8'h1A);
        chk(file_wdata, 8'h00);
        chk(zero_flag_reg, 1'b1);
        exec(12'h385, 8'h3C);
        chk(w_reg, 8'hC3);
        chk(zero_flag_reg, 1'b1);
        exec(12'h006, 8'h00);
        chk(dir_reg, 8'hC3);
        chk(zero_flag_reg, 1'b1);
    endtask
    // words that must be ignored: not issued, unknown, wrong operand; the not-issued word is then issued once and applied
    task automatic t_refuse;
        @(negedge core_clk);
        insn = 12'hF0F;
        @(negedge core_clk);
        chk(w_reg, 8'hC3);
        exec(12'hF0F, 8'h00);
        chk(w_reg, 8'hCC);
        exec(12'h0A5, 8'h00);
        chk(w_reg, 8'hCC);
        chk(file_we, 1'b0);
        chk(zero_we, 1'b0);
        exec(12'h005, 8'h00);
        chk(dir_reg, 8'hC3);
    endtask
    task automatic finish_test;
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        #5000;
        mismatches++;
        finish_test;
    end
    initial
    begin
        {rst, insn_valid, insn, file_rdata} = {1'b1, 1'b0, 12'h000, 8'h00};
        repeat (20) @(negedge core_clk);
        rst = 1'b0;
        chk(dir_reg, 8'hFF);
        chk(w_reg, 8'h00);
        chk(zero_flag_reg, 1'b0);
        chk(file_we, 1'b0);
        t_swap;
        t_dirl;
        t_xorl;
        t_xorf;
        t_flags;
        t_refuse;
        finish_test;
    end
endmodule // nibble_swap_direction_load_op_xor_exec_test
`default_nettype wire
